/* hdl/ufs_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef UFS_MAP_SVH
`define UFS_MAP_SVH

`define UFS_NUM_CH 4
`define UFS_ADDR_DATA 3'h0
`define UFS_ADDR_IER 3'h1
`define UFS_ADDR_FCR 3'h2
`define UFS_ADDR_LCR 3'h3
`define UFS_ADDR_MCR 3'h4
`define UFS_ADDR_LSR 3'h5
`define UFS_ADDR_MSR 3'h6
`define UFS_ADDR_SPR 3'h7
`define UFS_ADDR_TRG 3'h0
`define UFS_ADDR_FEATURE_CONTROL_REG 3'h1
`define UFS_ADDR_EFR 3'h2
`define UFS_ADDR_FLOW_RESUME_CHAR_ONE 3'h4
`define UFS_ADDR_FLOW_RESUME_CHAR_TWO 3'h5
`define UFS_ADDR_FLOW_PAUSE_CHAR_ONE 3'h6
`define UFS_ADDR_FLOW_PAUSE_CHAR_TWO 3'h7
`define UFS_LCR_ENH_KEY 8'hbf
`define UFS_LCR_DLAB 7
`define UFS_EFR_ENH_EN 4
`define UFS_EFR_AUTO_RTS 6
`define UFS_EFR_AUTO_CTS 7
`define UFS_MCR_DTR 0
`define UFS_MCR_RTS 1
`define UFS_MCR_INT_EN 3
`define UFS_MCR_IR_EN 6
`define UFS_FCR_DMA 3
`define UFS_FEATURE_CONTROL_REG_SWAP 6
`define UFS_IER_RX 0
`define UFS_IER_TX 1
`define UFS_IER_MS 3
`define UFS_ENH_MASK 8'hf0
`define UFS_ENH_MASK_FCR 8'h30
`define UFS_ENH_MASK_MCR 8'he0
`define UFS_RST_ZERO 8'h00
`define UFS_RST_SPR 8'hff
`define UFS_ISR_NONE 8'h01
`define UFS_ISR_RX 8'h04
`define UFS_ISR_TX 8'h02
`define UFS_ISR_MS 8'h00
`define UFS_TRIG_L0 8'h01
`define UFS_TRIG_L1 8'h04
`define UFS_TRIG_L2 8'h08
`define UFS_TRIG_L3 8'h0e
`define UFS_HYST_NEXT 8'h04
`define UFS_HYST_1 8'h04
`define UFS_HYST_2 8'h06
`define UFS_HYST_3 8'h08
`define UFS_BIT_CLKS 5'd16
`define UFS_SETTLE 2'd3

`endif

/* hdl/ufs_pkg.sv */
// Types shared by the flow control and status block
package ufs_pkg;

  typedef struct packed {
    logic [3:0] cs_n;
    logic [2:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] wdata;
  } ufs_bus_req_type;

  typedef struct packed {
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] scratch_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] trg;
    logic [7:0] enhanced_feature_control;
    logic [7:0] flow_resume_char_one;
    logic [7:0] flow_resume_char_two;
    logic [7:0] flow_pause_char_one;
    logic [7:0] flow_pause_char_two;
    logic [3:0] msr_delta;
    logic [3:0] msync1;
    logic [3:0] msync2;
    logic [3:0] mprev;
    logic rts_hold;
    logic rts_n;
    logic dtr_n;
    logic txr_n;
    logic rxr_n;
    logic int_lvl;
  } ufs_chan_type;

  typedef enum logic [1:0] {
    UFS_TX_IDLE = 2'b01,
    UFS_TX_SHIFT = 2'b10
  } ufs_tx_state_type;

endpackage

/* hdl/ufs_tx_buffer.sv */
// Two-entry transmit holding buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ufs_tx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ufs_buf_state_type;
  ufs_buf_state_type s_r, s_nxt;
  logic do_in, do_out;

  assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rp];

  always_comb begin
    s_nxt = s_r;
    do_in = in_valid_i & in_ready_o;
    do_out = out_valid_o & out_ready_i;
    if (do_in) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (do_out) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(do_in) - (AW+1)'(do_out);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

/* hdl/ufs_tx_shifter.sv */
// Serial transmitter that starts a character only when not paused
`timescale 1ns/1ps
`default_nettype none
module ufs_tx_shifter
  import ufs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [7:0] in_data_i,
  input wire logic [1:0] word_len_i,
  input wire logic pause_i,
  output logic tx_o,
  output logic busy_o
);
`include "ufs_map.svh"
  typedef struct packed {
    ufs_tx_state_type st;
    logic [9:0] shreg;
    logic [3:0] bits;
    logic [4:0] tick;
  } ufs_shift_state_type;
  ufs_shift_state_type s_r, s_nxt;
  logic [7:0] mask;

  // Pause is sampled only between characters
  assign in_ready_o = (s_r.st == UFS_TX_IDLE) & ~pause_i;
  assign tx_o = s_r.shreg[0];
  assign busy_o = (s_r.st == UFS_TX_SHIFT);

  always_comb begin
    s_nxt = s_r;
    mask = 8'hff >> (2'd3 - word_len_i);
    unique case (s_r.st)
      UFS_TX_IDLE: begin
        if (in_valid_i & ~pause_i) begin
          s_nxt.st = UFS_TX_SHIFT;
          s_nxt.shreg = {1'b1, in_data_i | ~mask, 1'b0};
          s_nxt.bits = 4'd7 + {2'b00, word_len_i};
          s_nxt.tick = 5'h00;
        end
      end
      UFS_TX_SHIFT: begin
        if (s_r.tick == `UFS_BIT_CLKS - 5'd1) begin
          s_nxt.tick = 5'h00;
          s_nxt.shreg = {1'b1, s_r.shreg[9:1]};
          if (s_r.bits == 4'd1) begin
            s_nxt.st = UFS_TX_IDLE;
          end else begin
            s_nxt.bits = s_r.bits - 4'd1;
          end
        end else begin
          s_nxt.tick = s_r.tick + 5'd1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_r.st <= UFS_TX_IDLE;
      s_r.shreg <= 10'h3ff;
      s_r.bits <= 4'h0;
      s_r.tick <= 5'h00;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

/* hdl/ufs_flow_status.sv */
// Four-channel UART flow control, status byte and register reset logic
`timescale 1ns/1ps
`default_nettype none
module ufs_flow_status
  import ufs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire ufs_bus_req_type bus_i,
  input wire logic status_read_select_n_i,
  output logic [7:0] rdata_o,
  output logic rdata_oe_o,
  input wire logic bus_mode_68_i,
  input wire logic interrupt_output_select_i,
  input wire logic [3:0][3:0] modem_n_i,
  input wire logic [3:0][7:0] rx_level_i,
  input wire logic [3:0][7:0] rx_data_i,
  output logic [3:0] rx_pop_o,
  output logic [3:0] tx_o,
  output logic [3:0] infrared_tx_out_o,
  output logic [3:0] rts_n_o,
  output logic [3:0] dtr_n_o,
  output logic [3:0] receive_ready_n_o,
  output logic [3:0] transmit_ready_n_o,
  output logic [3:0] int_o,
  output logic [3:0] int_oe_o,
  output logic irq_n_o,
  output logic irq_n_oe_o
);
`include "ufs_map.svh"

  typedef struct packed {
    ufs_chan_type [3:0] ch;
    logic wr_n_prev;
    logic rd_n_prev;
    logic [7:0] rdata;
    logic rdata_oe;
    logic [1:0] settle;
    logic [3:0] int_oe;
    logic irq_oe;
  } ufs_state_type;

  ufs_state_type s_r, s_nxt;
  logic [3:0] push;
  logic [3:0] pop;
  logic [3:0] buf_ready;
  logic [3:0] buf_valid;
  logic [3:0][7:0] buf_data;
  logic [3:0] shf_ready;
  logic [3:0] shf_busy;
  logic [3:0] pause;
  logic [7:0] combined_fifo_status;

  function automatic logic [7:0] trig_level(input ufs_chan_type c);
    logic [7:0] t;
    t = `UFS_TRIG_L0;
    if (c.feature_control_reg[5:4] == 2'b11) begin
      t = c.trg;
    end else begin
      unique case (c.fifo_control_reg[7:6])
        2'b00: t = `UFS_TRIG_L0;
        2'b01: t = `UFS_TRIG_L1;
        2'b10: t = `UFS_TRIG_L2;
        2'b11: t = `UFS_TRIG_L3;
      endcase
    end
    return t;
  endfunction

  function automatic logic [7:0] hyst_step(input logic [1:0] code);
    logic [7:0] h;
    h = `UFS_HYST_NEXT;
    unique case (code)
      2'b00: h = `UFS_HYST_NEXT;
      2'b01: h = `UFS_HYST_1;
      2'b10: h = `UFS_HYST_2;
      2'b11: h = `UFS_HYST_3;
    endcase
    return h;
  endfunction

  // Transmit path per channel: buffer then shifter
  for (genvar g = 0; g < 4; g++) begin : g_tx
    ufs_tx_buffer #(
      .WIDTH(8),
      .DEPTH(2)
    ) u_buf (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(push[g]),
      .in_ready_o(buf_ready[g]),
      .in_data_i(bus_i.wdata),
      .out_valid_o(buf_valid[g]),
      .out_ready_i(shf_ready[g]),
      .out_data_o(buf_data[g])
    );
    // Auto CTS uses the second synchroniser stage
    assign pause[g] = s_r.ch[g].enhanced_feature_control[`UFS_EFR_AUTO_CTS] & s_r.ch[g].msync2[0];
    ufs_tx_shifter u_shf (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(buf_valid[g]),
      .in_ready_o(shf_ready[g]),
      .in_data_i(buf_data[g]),
      .word_len_i(s_r.ch[g].line_control_reg[1:0]),
      .pause_i(pause[g]),
      .tx_o(tx_o[g]),
      .busy_o(shf_busy[g])
    );
    assign infrared_tx_out_o[g] = s_r.ch[g].modem_control_reg[`UFS_MCR_IR_EN] & ~tx_o[g];
    assign rts_n_o[g] = s_r.ch[g].rts_n;
    assign dtr_n_o[g] = s_r.ch[g].dtr_n;
    assign receive_ready_n_o[g] = s_r.ch[g].rxr_n;
    assign transmit_ready_n_o[g] = s_r.ch[g].txr_n;
    assign int_o[g] = s_r.ch[g].int_lvl;
  end

  assign combined_fifo_status = {s_r.ch[3].rxr_n, s_r.ch[2].rxr_n, s_r.ch[1].rxr_n, s_r.ch[0].rxr_n,
                  ~s_r.ch[3].txr_n, ~s_r.ch[2].txr_n, ~s_r.ch[1].txr_n, ~s_r.ch[0].txr_n};
  assign rdata_o = s_r.rdata;
  assign rdata_oe_o = s_r.rdata_oe;
  assign int_oe_o = s_r.int_oe;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = s_r.irq_oe;
  assign rx_pop_o = pop;

  always_comb begin
    ufs_chan_type c;
    ufs_chan_type n;
    logic sel_ok;
    logic [1:0] sel;
    logic wr_go;
    logic rd_go;
    logic wr_c;
    logic rd_c;
    logic enh;
    logic [7:0] rd_mux;
    logic [7:0] trig;
    logic [8:0] upper;
    logic [7:0] lower;
    logic [7:0] step;
    logic [3:0] newd;
    logic [7:0] interrupt_status_reg;
    logic [7:0] line_status_reg;
    logic pend;
    logic any_pend;
    c = '0;
    n = '0;
    sel_ok = 1'b0;
    sel = 2'd0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wr_c = 1'b0;
    rd_c = 1'b0;
    enh = 1'b0;
    rd_mux = 8'h00;
    trig = 8'h00;
    upper = 9'h000;
    lower = 8'h00;
    step = 8'h00;
    newd = 4'h0;
    interrupt_status_reg = `UFS_ISR_NONE;
    line_status_reg = 8'h00;
    pend = 1'b0;
    any_pend = 1'b0;
    push = 4'h0;
    pop = 4'h0;
    s_nxt = s_r;

    // Lowest-numbered selected channel answers
    for (int k = 3; k >= 0; k--) begin
      if (!bus_i.cs_n[k]) begin
        sel_ok = 1'b1;
        sel = 2'(k);
      end
    end
    wr_go = sel_ok & ~bus_i.wr_n & s_r.wr_n_prev;
    rd_go = sel_ok & ~bus_i.rd_n & s_r.rd_n_prev;
    s_nxt.wr_n_prev = bus_i.wr_n;
    s_nxt.rd_n_prev = bus_i.rd_n;
    if (s_r.settle != `UFS_SETTLE) begin
      s_nxt.settle = s_r.settle + 2'd1;
    end

    for (int k = 0; k < 4; k++) begin
      c = s_r.ch[k];
      n = c;
      wr_c = wr_go & (sel == 2'(k));
      rd_c = rd_go & (sel == 2'(k));
      enh = (c.line_control_reg == `UFS_LCR_ENH_KEY);

      // Modem input synchroniser; deltas held off until it has settled
      n.msync1 = modem_n_i[k];
      n.msync2 = c.msync1;
      n.mprev = c.msync2;
      newd = (s_r.settle == `UFS_SETTLE) ? (c.msync2 ^ c.mprev) : 4'h0;

      // Receive trigger and hysteresis thresholds
      trig = trig_level(c);
      step = hyst_step(c.feature_control_reg[1:0]);
      upper = {1'b0, trig} + {1'b0, step};
      lower = (trig > step) ? (trig - step) : 8'h00;
      if ({1'b0, rx_level_i[k]} >= upper) begin
        n.rts_hold = 1'b1;
      end else if (rx_level_i[k] < lower) begin
        n.rts_hold = 1'b0;
      end

      line_status_reg = 8'h00;
      line_status_reg[0] = (rx_level_i[k] != 8'h00);
      line_status_reg[5] = ~buf_valid[k];
      line_status_reg[6] = ~buf_valid[k] & ~shf_busy[k];
      pend = 1'b0;
      interrupt_status_reg = `UFS_ISR_NONE;
      if (c.interrupt_enable_reg[`UFS_IER_RX] && rx_level_i[k] >= trig) begin
        pend = 1'b1;
        interrupt_status_reg = `UFS_ISR_RX;
      end else if (c.interrupt_enable_reg[`UFS_IER_TX] && !buf_valid[k]) begin
        pend = 1'b1;
        interrupt_status_reg = `UFS_ISR_TX;
      end else if (c.interrupt_enable_reg[`UFS_IER_MS] && c.msr_delta != 4'h0) begin
        pend = 1'b1;
        interrupt_status_reg = `UFS_ISR_MS;
      end

      // Register writes
      if (wr_c) begin
        if (enh) begin
          unique case (bus_i.addr)
            `UFS_ADDR_TRG: n.trg = bus_i.wdata;
            `UFS_ADDR_FEATURE_CONTROL_REG: n.feature_control_reg = bus_i.wdata;
            `UFS_ADDR_EFR: n.enhanced_feature_control = bus_i.wdata;
            `UFS_ADDR_LCR: n.line_control_reg = bus_i.wdata;
            `UFS_ADDR_FLOW_RESUME_CHAR_ONE: n.flow_resume_char_one = bus_i.wdata;
            `UFS_ADDR_FLOW_RESUME_CHAR_TWO: n.flow_resume_char_two = bus_i.wdata;
            `UFS_ADDR_FLOW_PAUSE_CHAR_ONE: n.flow_pause_char_one = bus_i.wdata;
            `UFS_ADDR_FLOW_PAUSE_CHAR_TWO: n.flow_pause_char_two = bus_i.wdata;
            default: n.line_control_reg = c.line_control_reg;
          endcase
        end else begin
          unique case (bus_i.addr)
            `UFS_ADDR_DATA: push[k] = ~c.line_control_reg[`UFS_LCR_DLAB];
            `UFS_ADDR_IER: begin
              if (!c.line_control_reg[`UFS_LCR_DLAB]) begin
                n.interrupt_enable_reg = c.enhanced_feature_control[`UFS_EFR_ENH_EN] ? bus_i.wdata :
                        ((c.interrupt_enable_reg & `UFS_ENH_MASK) | (bus_i.wdata & ~`UFS_ENH_MASK));
              end
            end
            `UFS_ADDR_FCR: n.fifo_control_reg = c.enhanced_feature_control[`UFS_EFR_ENH_EN] ? bus_i.wdata :
                           ((c.fifo_control_reg & `UFS_ENH_MASK_FCR) | (bus_i.wdata & ~`UFS_ENH_MASK_FCR));
            `UFS_ADDR_LCR: n.line_control_reg = bus_i.wdata;
            `UFS_ADDR_MCR: n.modem_control_reg = c.enhanced_feature_control[`UFS_EFR_ENH_EN] ? bus_i.wdata :
                           ((c.modem_control_reg & `UFS_ENH_MASK_MCR) | (bus_i.wdata & ~`UFS_ENH_MASK_MCR));
            `UFS_ADDR_SPR: begin
              if (!c.feature_control_reg[`UFS_FEATURE_CONTROL_REG_SWAP]) begin
                n.scratch_reg = bus_i.wdata;
              end
            end
            default: n.line_control_reg = c.line_control_reg;
          endcase
        end
      end

      // Read data for the selected channel
      if (sel == 2'(k)) begin
        if (enh) begin
          unique case (bus_i.addr)
            `UFS_ADDR_TRG: rd_mux = rx_level_i[k];
            `UFS_ADDR_FEATURE_CONTROL_REG: rd_mux = c.feature_control_reg;
            `UFS_ADDR_EFR: rd_mux = c.enhanced_feature_control;
            `UFS_ADDR_LCR: rd_mux = c.line_control_reg;
            `UFS_ADDR_FLOW_RESUME_CHAR_ONE: rd_mux = c.flow_resume_char_one;
            `UFS_ADDR_FLOW_RESUME_CHAR_TWO: rd_mux = c.flow_resume_char_two;
            `UFS_ADDR_FLOW_PAUSE_CHAR_ONE: rd_mux = c.flow_pause_char_one;
            `UFS_ADDR_FLOW_PAUSE_CHAR_TWO: rd_mux = c.flow_pause_char_two;
          endcase
        end else begin
          unique case (bus_i.addr)
            `UFS_ADDR_DATA: rd_mux = c.line_control_reg[`UFS_LCR_DLAB] ? 8'h00 : rx_data_i[k];
            `UFS_ADDR_IER: rd_mux = c.line_control_reg[`UFS_LCR_DLAB] ? 8'h00 : c.interrupt_enable_reg;
            `UFS_ADDR_FCR: rd_mux = interrupt_status_reg;
            `UFS_ADDR_LCR: rd_mux = c.line_control_reg;
            `UFS_ADDR_MCR: rd_mux = c.modem_control_reg;
            `UFS_ADDR_LSR: rd_mux = line_status_reg;
            `UFS_ADDR_MSR: rd_mux = {~c.msync2, c.msr_delta};
            `UFS_ADDR_SPR: rd_mux = c.feature_control_reg[`UFS_FEATURE_CONTROL_REG_SWAP] ? rx_level_i[k] : c.scratch_reg;
          endcase
        end
      end
      if (rd_c && !enh && bus_i.addr == `UFS_ADDR_DATA && !c.line_control_reg[`UFS_LCR_DLAB]) begin
        pop[k] = (rx_level_i[k] != 8'h00);
      end

      // A new modem change wins over the clear by an MODEM_STATUS_REG read
      if (rd_c && !enh && bus_i.addr == `UFS_ADDR_MSR) begin
        n.msr_delta = newd;
      end else begin
        n.msr_delta = c.msr_delta | newd;
      end

      // RTS pin: automatic only with enable and software assertion
      if (n.enhanced_feature_control[`UFS_EFR_AUTO_RTS]) begin
        n.rts_n = n.modem_control_reg[`UFS_MCR_RTS] ? n.rts_hold : 1'b1;
      end else begin
        n.rts_n = ~n.modem_control_reg[`UFS_MCR_RTS];
      end
      n.dtr_n = ~n.modem_control_reg[`UFS_MCR_DTR];
      n.txr_n = ~buf_ready[k];
      if (c.fifo_control_reg[`UFS_FCR_DMA]) begin
        n.rxr_n = (rx_level_i[k] < trig);
      end else begin
        n.rxr_n = (rx_level_i[k] == 8'h00);
      end
      n.int_lvl = pend;
      s_nxt.int_oe[k] = ~bus_mode_68_i & c.modem_control_reg[`UFS_MCR_INT_EN];
      any_pend = any_pend | pend;
      s_nxt.ch[k] = n;
    end

    s_nxt.irq_oe = bus_mode_68_i & ~interrupt_output_select_i & any_pend;
    if (!status_read_select_n_i) begin
      s_nxt.rdata = combined_fifo_status;
    end else if (rd_go) begin
      s_nxt.rdata = rd_mux;
    end
    s_nxt.rdata_oe = ~status_read_select_n_i | (sel_ok & ~bus_i.rd_n);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < 4; k++) begin
        s_r.ch[k] <= '0;
        s_r.ch[k].scratch_reg <= `UFS_RST_SPR;
        s_r.ch[k].enhanced_feature_control <= `UFS_RST_ZERO;
        s_r.ch[k].msr_delta <= 4'h0;
        s_r.ch[k].msync1 <= 4'hf;
        s_r.ch[k].msync2 <= 4'hf;
        s_r.ch[k].mprev <= 4'hf;
        s_r.ch[k].rts_n <= 1'b1;
        s_r.ch[k].dtr_n <= 1'b1;
        s_r.ch[k].txr_n <= 1'b0;
        s_r.ch[k].rxr_n <= 1'b1;
      end
      s_r.wr_n_prev <= 1'b1;
      s_r.rd_n_prev <= 1'b1;
      s_r.rdata <= 8'h00;
      s_r.rdata_oe <= 1'b0;
      s_r.settle <= 2'd0;
      s_r.int_oe <= 4'h0;
      s_r.irq_oe <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

/* dv/ufs_flow_status_monitor.sv */
// Port checker for the flow control and status block
`timescale 1ns/1ps
`default_nettype none
module ufs_flow_status_monitor
  import ufs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire ufs_bus_req_type bus_i,
  input wire logic status_read_select_n_i,
  input wire logic [7:0] rdata_o,
  input wire logic rdata_oe_o,
  input wire logic bus_mode_68_i,
  input wire logic interrupt_output_select_i,
  input wire logic [3:0][7:0] rx_level_i,
  input wire logic [3:0] tx_o,
  input wire logic [3:0] infrared_tx_out_o,
  input wire logic [3:0] rts_n_o,
  input wire logic [3:0] dtr_n_o,
  input wire logic [3:0] receive_ready_n_o,
  input wire logic [3:0] transmit_ready_n_o,
  input wire logic [3:0] int_oe_o,
  input wire logic irq_n_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  reset_pins_a: assert property ($fell(reset_i) |-> tx_o == 4'hf && rts_n_o == 4'hf
    && dtr_n_o == 4'hf && receive_ready_n_o == 4'hf && transmit_ready_n_o == 4'h0
    && infrared_tx_out_o == 4'h0 && int_oe_o == 4'h0 && !irq_n_oe_o)
    else $error("pin levels wrong after reset");
  status_byte_a: assert property (!status_read_select_n_i |=> rdata_oe_o
    && rdata_o == {$past(receive_ready_n_o), ~$past(transmit_ready_n_o)})
    else $error("status byte wrong");
  status_release_a: assert property (bus_i.rd_n && status_read_select_n_i |=> !rdata_oe_o)
    else $error("data bus driven without select");
  read_answer_a: assert property ($fell(bus_i.rd_n) && bus_i.cs_n != 4'hf |=> rdata_oe_o)
    else $error("read not answered");
  irq_mode_a: assert property (irq_n_oe_o |-> $past(bus_mode_68_i)
    && !$past(interrupt_output_select_i)) else $error("irq pulled outside its mode");
  int_tristate_a: assert property (bus_mode_68_i && $past(bus_mode_68_i) |-> int_oe_o == 4'h0)
    else $error("int pin driven in 68 mode");
  start_bit_a: assert property ($fell(tx_o[0]) |=> !tx_o[0] [*8])
    else $error("start bit cut short");
  rts_cause_a: assert property ($changed(rts_n_o) |-> !$past(bus_i.wr_n)
    || !$past(bus_i.wr_n, 2) || !$past(bus_i.wr_n, 3)
    || $past(rx_level_i) != $past(rx_level_i, 2) || $past(rx_level_i, 2) != $past(rx_level_i, 3))
    else $error("rts moved without cause");
  cover property (!status_read_select_n_i ##1 transmit_ready_n_o[0]);
  cover property ($fell(tx_o[0]));
  cover property ($rose(rts_n_o[0]));
endmodule
bind ufs_flow_status ufs_flow_status_monitor i_mon (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .bus_i(bus_i), .status_read_select_n_i(status_read_select_n_i), .rdata_o(rdata_o),
  .rdata_oe_o(rdata_oe_o), .bus_mode_68_i(bus_mode_68_i),
  .interrupt_output_select_i(interrupt_output_select_i), .rx_level_i(rx_level_i),
  .tx_o(tx_o), .infrared_tx_out_o(infrared_tx_out_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .receive_ready_n_o(receive_ready_n_o), .transmit_ready_n_o(transmit_ready_n_o),
  .int_oe_o(int_oe_o), .irq_n_oe_o(irq_n_oe_o));
`default_nettype wire

/* dv/ufs_peer_model.sv */
// Remote serial peer: drives channel 0 modem lines and receives its characters
`timescale 1ns/1ps
`default_nettype none
module ufs_peer_model (
  input wire logic sys_clk_i,
  input wire logic hold_i,
  input wire logic tx_i,
  output logic [3:0] modem_n_o,
  output logic [7:0] rx_byte_o,
  output logic [7:0] rx_count_o
);
  // Clear-to-send follows the hold command; other modem lines sit at fixed levels
  assign modem_n_o = {3'b010, hold_i};
  initial begin
    rx_byte_o = 8'h00;
    rx_count_o = 8'h00;
    forever begin
      @(negedge tx_i);
      repeat (8) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge sys_clk_i);
        rx_byte_o[i] = tx_i;
      end
      repeat (16) @(posedge sys_clk_i);
      if (tx_i) begin
        rx_count_o = rx_count_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ufs_flow_status_bench.sv */
// Self-checking bench for the flow control and status block
`timescale 1ns/1ps
`default_nettype none
module ufs_flow_status_bench
  import ufs_pkg::*;
;
  localparam ufs_bus_req_type BUS_IDLE = '{4'hf, 3'h0, 1'b1, 1'b1, 8'h00};
  logic sys_clk_i, reset_i, fsel_n, hold, rdata_oe, irq_n, irq_oe, mode_68;
  ufs_bus_req_type bus;
  logic [3:0][7:0] level;
  logic [7:0] rdata, got, peer_byte, peer_cnt;
  logic [3:0] rx_pop, tx, infrared_tx_out, rts_n, dtr_n, rxr_n, txr_n, int_l, int_oe, peer_modem;
  int n_errors, comparisons;
  ufs_flow_status i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus),
    .status_read_select_n_i(fsel_n), .rdata_o(rdata), .rdata_oe_o(rdata_oe),
    .bus_mode_68_i(mode_68), .interrupt_output_select_i(1'b0),
    .modem_n_i({4'hf, 4'hf, 4'hf, peer_modem}), .rx_level_i(level),
    .rx_data_i({4{8'h5a}}), .rx_pop_o(rx_pop), .tx_o(tx), .infrared_tx_out_o(infrared_tx_out),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .receive_ready_n_o(rxr_n),
    .transmit_ready_n_o(txr_n), .int_o(int_l), .int_oe_o(int_oe), .irq_n_o(irq_n),
    .irq_n_oe_o(irq_oe));
  ufs_peer_model i_peer (.sys_clk_i(sys_clk_i), .hold_i(hold), .tx_i(tx[0]),
    .modem_n_o(peer_modem), .rx_byte_o(peer_byte), .rx_count_o(peer_cnt));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    bus = '{4'he, a, 1'b1, 1'b0, d};
    @(negedge sys_clk_i);
    bus = BUS_IDLE;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    bus = '{4'he, a, 1'b0, 1'b1, 8'h00};
    repeat (2) @(negedge sys_clk_i);
    got = rdata;
    bus = BUS_IDLE;
    chk(name, exp, got);
  endtask
  task automatic combined_fifo_status(input logic [7:0] exp);
    @(negedge sys_clk_i);
    fsel_n = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk("combined_fifo_status", exp, rdata);
    fsel_n = 1'b1;
  endtask
  task automatic wait_tx_start();
    int k;
    k = 0;
    while (tx[0] !== 1'b0 && k < 40) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 40) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic wait_peer(input logic [7:0] n, input logic [7:0] exp);
    int k;
    k = 0;
    while (peer_cnt !== n && k < 400) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 400) begin
      n_errors++;
      print_verdict();
    end
    chk("peer_byte", exp, peer_byte);
  endtask
  task automatic idle_tx();
    got = 8'h01;
    repeat (60) begin
      @(negedge sys_clk_i);
      got[0] = got[0] & tx[0];
    end
    chk("paused_tx", 8'h01, got);
  endtask
  logic [7:0] gen_rst [1:7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hb0, 8'hff};
  logic [7:0] lv [4] = '{8'h0b, 8'h0c, 8'h05, 8'h03};
  logic [3:0] rt = 4'b0110;
  initial begin
    bus = BUS_IDLE;
    fsel_n = 1'b1;
    hold = 1'b0;
    mode_68 = 1'b1;
    level = '0;
    n_errors = 0;
    comparisons = 0;
    reset_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    reset_i = 1'b0;
    chk("tx_rts", 8'hff, {tx, rts_n});
    chk("dtr_rxr", 8'hff, {dtr_n, rxr_n});
    chk("txr_infrared_tx_out", 8'h00, {txr_n, infrared_tx_out});
    chk("int_irq", 8'h00, {int_oe, 3'h0, irq_oe});
    for (int a = 1; a < 8; a++) rchk("general_reg", 3'(a), gen_rst[a]);
    combined_fifo_status(8'hff);
    wr(3'h4, 8'h02);
    chk("rts_dtr_sw", 8'h01, {6'h0, rts_n[0], dtr_n[0]});
    wr(3'h4, 8'h01);
    chk("rts_dtr_sw", 8'h02, {6'h0, rts_n[0], dtr_n[0]});
    wr(3'h3, 8'hbf);
    for (int a = 1; a < 8; a++) if (a != 3) rchk("enhanced_reg", 3'(a), 8'h00);
    for (int a = 4; a < 8; a++) wr(3'(a), 8'ha0 | 8'(a));
    for (int a = 4; a < 8; a++) rchk("flow_char", 3'(a), 8'ha0 | 8'(a));
    wr(3'h2, 8'h40);
    wr(3'h3, 8'h03);
    wr(3'h2, 8'h81);
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h00);
    chk("rts_auto_off", 8'h01, {7'h0, rts_n[0]});
    wr(3'h4, 8'h02);
    for (int i = 0; i < 4; i++) begin
      level[0] = lv[i];
      repeat (4) @(negedge sys_clk_i);
      chk("rts_auto", {7'h0, rt[i]}, {7'h0, rts_n[0]});
    end
    level[0] = 8'h08;
    rchk("interrupt_status_reg", 3'h2, 8'h04);
    chk("int_irq_pend", 8'h03, {6'h0, int_l[0], irq_oe});
    chk("rts_auto", 8'h00, {7'h0, rts_n[0]});
    level[0] = 8'h00;
    hold = 1'b1;
    wr(3'h0, 8'ha5);
    wait_tx_start();
    wait_peer(8'h01, 8'ha5);
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'hc0);
    wr(3'h3, 8'h03);
    wr(3'h0, 8'h3c);
    wr(3'h0, 8'h96);
    idle_tx();
    combined_fifo_status(8'hfe);
    hold = 1'b0;
    wait_tx_start();
    repeat (40) @(negedge sys_clk_i);
    hold = 1'b1;
    wait_peer(8'h02, 8'h3c);
    idle_tx();
    hold = 1'b0;
    wait_peer(8'h03, 8'h96);
    // Channel 1 holds data, so its receive-ready bit drops in the status byte
    level[1] = 8'h05;
    combined_fifo_status(8'hdf);
    // Leave 68 mode: the interrupt pin is driven and the open-drain request released
    mode_68 = 1'b0;
    wr(3'h4, 8'h0a);
    chk("int_oe_16", 8'h02, {3'h0, int_oe, irq_oe});
    print_verdict();
  end
endmodule
`default_nettype wire
